// ### shared/mrx_exec_pkg.sv
package mrx_exec_pkg;

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [1:0]
   {
      MRX_ST_EXEC   = 2'h1,
      MRX_ST_SECOND = 2'h2
   } mrx_state_type;

   // ****************************************************************
   // Decoded instruction kinds
   // ****************************************************************
   typedef enum logic [2:0]
   {
      MRX_K_IDLE    = 3'h0,
      MRX_K_STORE   = 3'h1,
      MRX_K_LOADLIT = 3'h2,
      MRX_K_IRET    = 3'h3,
      MRX_K_RETLIT  = 3'h4,
      MRX_K_RETURN  = 3'h5
   } mrx_kind_type;

endpackage : mrx_exec_pkg

// ### shared/mrx_exec_regs.svh
`ifndef MRX_EXEC_REGS_SVH
`define MRX_EXEC_REGS_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define MRX_PC_RESET       13'h0000
`define MRX_ACC_RESET      8'h00
`define MRX_IRQCTL_RESET   8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define MRX_GIE_BIT        3'h7
`define MRX_IRQCTL_ADDR    7'h0B

// ****************************************************************
// Opcode patterns, exact words or compared under a mask
// ****************************************************************
`define MRX_OP_IDLE        14'h0000
`define MRX_OP_RETURN      14'h0008
`define MRX_OP_IRET        14'h0009
`define MRX_STORE_MASK     14'h3F80
`define MRX_STORE_MATCH    14'h0080
`define MRX_LIT_MASK       14'h3C00
`define MRX_LOADLIT_MATCH  14'h3000
`define MRX_RETLIT_MATCH   14'h3400

// ****************************************************************
// Timing counts, in instruction cycles
// ****************************************************************
`define MRX_CYC_SHORT      2'h1
`define MRX_CYC_LONG       2'h2

`endif

// ### test/mrx_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrx_exec_regs.svh"

module mrx_exec_asserts
#(
   parameter int PC_W        = 13,
   parameter int STACK_DEPTH = 8
)
(
   // Clock and reset
   input wire logic            mclk_i,
   input wire logic            rst_i,
   // Instruction fetch
   input wire logic [13:0]     instr_i,
   input wire logic            instr_valid_i,
   input wire logic            instr_ready_o,
   // Call and interrupt entry
   input wire logic            call_push_i,
   input wire logic [PC_W-1:0] call_addr_i,
   input wire logic            irq_entry_i,
   // File write and core state
   input wire logic            file_we_o,
   input wire logic [6:0]      file_addr_o,
   input wire logic [7:0]      file_data_o,
   input wire logic [PC_W-1:0] pc_o,
   input wire logic [7:0]      acc_o,
   input wire logic [7:0]      interrupt_control_reg_o,
   input wire logic            global_irq_enable_o
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   logic take;
   logic is_ret;
   assign take   = instr_valid_i && instr_ready_o;
   assign is_ret = instr_i == `MRX_OP_RETURN || instr_i == `MRX_OP_IRET
                   || (instr_i & `MRX_LIT_MASK) == `MRX_RETLIT_MATCH;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_store;
      take && (instr_i & `MRX_STORE_MASK) == `MRX_STORE_MATCH |=> file_we_o && file_addr_o == $past(instr_i[6:0])
         && file_data_o == $past(acc_o) && pc_o == $past(pc_o) + 1'b1;
   endproperty
   a_store: assert property (p_store) else $error("store result wrong");

   property p_we_cause;
      file_we_o |-> $past(take) && ($past(instr_i) & `MRX_STORE_MASK) == `MRX_STORE_MATCH;
   endproperty
   a_we_cause: assert property (p_we_cause) else $error("file write without store");

   property p_loadlit;
      take && (instr_i & `MRX_LIT_MASK) == `MRX_LOADLIT_MATCH |=> acc_o == $past(instr_i[7:0])
         && pc_o == $past(pc_o) + 1'b1 && instr_ready_o;
   endproperty
   a_loadlit: assert property (p_loadlit) else $error("literal load wrong");

   property p_ret_two;
      take && is_ret |=> !instr_ready_o ##1 instr_ready_o;
   endproperty
   a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

   property p_iret_gie;
      take && instr_i == `MRX_OP_IRET |=> ##1 global_irq_enable_o;
   endproperty
   a_iret_gie: assert property (p_iret_gie) else $error("enable not set by interrupt return");

   property p_gie_bit;
      global_irq_enable_o == interrupt_control_reg_o[7];
   endproperty
   a_gie_bit: assert property (p_gie_bit) else $error("enable bit out of place");

   property p_retlit;
      take && (instr_i & `MRX_LIT_MASK) == `MRX_RETLIT_MATCH |=> acc_o == $past(instr_i[7:0]) && !file_we_o;
   endproperty
   a_retlit: assert property (p_retlit) else $error("return literal wrong");

   property p_return;
      take && instr_i == `MRX_OP_RETURN && !irq_entry_i |=> acc_o == $past(acc_o)
         && global_irq_enable_o == $past(global_irq_enable_o);
   endproperty
   a_return: assert property (p_return) else $error("return touched state");

   property p_idle;
      take && instr_i == `MRX_OP_IDLE |=> pc_o == $past(pc_o) + 1'b1 && $stable(acc_o) && !file_we_o && instr_ready_o;
   endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");
endmodule : mrx_exec_asserts

bind mrx_exec mrx_exec_asserts #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH)) u_mrx_exec_asserts
(
   .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
   .instr_ready_o(instr_ready_o), .call_push_i(call_push_i), .call_addr_i(call_addr_i),
   .irq_entry_i(irq_entry_i), .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_data_o(file_data_o),
   .pc_o(pc_o), .acc_o(acc_o), .interrupt_control_reg_o(interrupt_control_reg_o),
   .global_irq_enable_o(global_irq_enable_o)
);

`default_nettype wire

// ### test/mrx_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrx_exec_regs.svh"

module mrx_exec_tb_top;
   logic        mclk_i, rst_i, instr_valid_i, call_push_i, irq_entry_i;
   logic [13:0] instr_i;
   logic [12:0] call_addr_i, pc_o, exp_pc;
   logic        instr_ready_o, file_we_o, global_irq_enable_o;
   logic [6:0]  file_addr_o;
   logic [7:0]  file_data_o, acc_o, interrupt_control_reg_o;
   int          fail_count = 0;
   int          n_compared = 0;

   mrx_exec u_mrx_exec
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .instr_ready_o(instr_ready_o), .call_push_i(call_push_i), .call_addr_i(call_addr_i),
      .irq_entry_i(irq_entry_i), .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_data_o(file_data_o),
      .pc_o(pc_o), .acc_o(acc_o), .interrupt_control_reg_o(interrupt_control_reg_o),
      .global_irq_enable_o(global_irq_enable_o)
   );

   initial
   begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   // ****************************************************************
   // Compare and verdict
   // ****************************************************************
   task print_verdict;
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   task cmp13(input logic [12:0] got, input logic [12:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: pc %h expected %h", $time, got, exp);
      end
   endtask : cmp13

   task cmp1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : cmp1

   // ****************************************************************
   // Drivers, entered and left at a falling edge
   // ****************************************************************
   // Valid is held through refused cycles; last drops it after the take
   task issue(input logic [13:0] w, input logic last);
      int n;
      n = 0;
      instr_valid_i = 1'b1;
      instr_i = w;
      while (instr_ready_o !== 1'b1 && n < 10)
      begin
         n++;
         @(negedge mclk_i);
      end
      if (n == 10)
      begin
         fail_count++;
         $display("wrong value at %0t: instruction never taken", $time);
      end
      @(negedge mclk_i);
      if (last)
         instr_valid_i = 1'b0;
   endtask : issue

   // Pushes back to back keep the strobe up; last drops it
   task push(input logic [12:0] a, input logic last);
      call_push_i = 1'b1;
      call_addr_i = a;
      @(negedge mclk_i);
      if (last)
         call_push_i = 1'b0;
   endtask : push

   task do_reset;
      rst_i = 1'b1;
      repeat (6) @(negedge mclk_i);
      cmp13(pc_o, 13'h0000);
      cmp8(acc_o, 8'h00);
      cmp8(interrupt_control_reg_o, 8'h00);
      cmp1(file_we_o, 1'b0);
      cmp1(instr_ready_o, 1'b0);
      rst_i = 1'b0;
      exp_pc = 13'h0000;
      @(negedge mclk_i);
      cmp1(instr_ready_o, 1'b1);
   endtask : do_reset

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_literal_store;
      issue(`MRX_LOADLIT_MATCH | 14'h00FF, 1'b0);
      exp_pc = exp_pc + 13'h0001;
      cmp8(acc_o, 8'hFF);
      cmp13(pc_o, exp_pc);
      issue(`MRX_STORE_MATCH | 14'h007F, 1'b0);
      exp_pc = exp_pc + 13'h0001;
      cmp1(file_we_o, 1'b1);
      cmp8({1'b0, file_addr_o}, 8'h7F);
      cmp8(file_data_o, 8'hFF);
      cmp13(pc_o, exp_pc);
      issue(`MRX_LOADLIT_MATCH, 1'b0);
      cmp1(file_we_o, 1'b0);
      cmp8(acc_o, 8'h00);
      issue(`MRX_LOADLIT_MATCH | 14'h0080, 1'b0);
      issue(`MRX_STORE_MATCH | 14'h000B, 1'b1);
      exp_pc = exp_pc + 13'h0003;
      cmp8(interrupt_control_reg_o, 8'h80);
      cmp1(global_irq_enable_o, 1'b1);
      irq_entry_i = 1'b1;
      @(negedge mclk_i);
      irq_entry_i = 1'b0;
      cmp1(global_irq_enable_o, 1'b0);
   endtask : t_literal_store

   // Last in, first out: the later push returns first
   task t_returns;
      push(13'h0123, 1'b0);
      push(13'h1FFE, 1'b1);
      issue(`MRX_OP_RETURN, 1'b0);
      cmp1(instr_ready_o, 1'b0);
      cmp13(pc_o, 13'h1FFE);
      cmp8(acc_o, 8'h80);
      cmp1(global_irq_enable_o, 1'b0);
      issue(`MRX_RETLIT_MATCH | 14'h0042, 1'b1);
      cmp1(instr_ready_o, 1'b0);
      cmp13(pc_o, 13'h0123);
      cmp8(acc_o, 8'h42);
      push(13'h0ABC, 1'b1);
      issue(`MRX_OP_IRET, 1'b1);
      cmp13(pc_o, 13'h0ABC);
      cmp1(instr_ready_o, 1'b0);
      // Clear in the completing cycle loses to the set
      irq_entry_i = 1'b1;
      @(negedge mclk_i);
      irq_entry_i = 1'b0;
      cmp1(global_irq_enable_o, 1'b1);
      issue(`MRX_OP_IDLE, 1'b1);
      cmp13(pc_o, 13'h0ABD);
      cmp8(acc_o, 8'h42);
      cmp1(file_we_o, 1'b0);
   endtask : t_returns

   initial
   begin
      instr_i = 14'h0000;
      instr_valid_i = 1'b0;
      call_push_i = 1'b0;
      call_addr_i = 13'h0000;
      irq_entry_i = 1'b0;
      do_reset();
      t_literal_store();
      t_returns();
      do_reset();
      print_verdict();
   end

   // Whole run is under a hundred cycles
   initial
   begin
      repeat (400) @(posedge mclk_i);
      fail_count++;
      print_verdict();
   end
endmodule : mrx_exec_tb_top

`default_nettype wire

// ### verilog/mrx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "mrx_exec_regs.svh"

module mrx_exec
#(
   parameter int PC_W        = 13,
   parameter int STACK_DEPTH = 8
)
(
   // Clock and reset
   input  wire logic            mclk_i,
   input  wire logic            rst_i,
   // Instruction fetch
   input  wire logic [13:0]     instr_i,
   input  wire logic            instr_valid_i,
   output logic                 instr_ready_o,
   // Call and interrupt entry
   input  wire logic            call_push_i,
   input  wire logic [PC_W-1:0] call_addr_i,
   input  wire logic            irq_entry_i,
   // File register write port
   output logic                 file_we_o,
   output logic [6:0]           file_addr_o,
   output logic [7:0]           file_data_o,
   // Core state
   output logic [PC_W-1:0]      pc_o,
   output logic [7:0]           acc_o,
   output logic [7:0]           interrupt_control_reg_o,
   output logic                 global_irq_enable_o
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (PC_W < 8 || PC_W > 16)
   begin : g_bad_pc
      $error("mrx_exec: PC_W must lie between 8 and 16");
   end

   // ****************************************************************
   // Decoder
   // ****************************************************************
   function automatic mrx_exec_pkg::mrx_kind_type decode(input logic [13:0] w);
      mrx_exec_pkg::mrx_kind_type k;
      k = mrx_exec_pkg::MRX_K_IDLE;
      if ((w & `MRX_STORE_MASK) == `MRX_STORE_MATCH)
         k = mrx_exec_pkg::MRX_K_STORE;
      else if ((w & `MRX_LIT_MASK) == `MRX_LOADLIT_MATCH)
         k = mrx_exec_pkg::MRX_K_LOADLIT;
      else if ((w & `MRX_LIT_MASK) == `MRX_RETLIT_MATCH)
         k = mrx_exec_pkg::MRX_K_RETLIT;
      else if (w == `MRX_OP_IRET)
         k = mrx_exec_pkg::MRX_K_IRET;
      else if (w == `MRX_OP_RETURN)
         k = mrx_exec_pkg::MRX_K_RETURN;
      return k;
   endfunction : decode

   function automatic logic is_return(input mrx_exec_pkg::mrx_kind_type k);
      return (k == mrx_exec_pkg::MRX_K_IRET) || (k == mrx_exec_pkg::MRX_K_RETLIT) ||
             (k == mrx_exec_pkg::MRX_K_RETURN);
   endfunction : is_return

   mrx_exec_pkg::mrx_state_type state_q;
   mrx_exec_pkg::mrx_state_type state_d;
   mrx_exec_pkg::mrx_kind_type  kind;
   mrx_exec_pkg::mrx_kind_type  kind_q;
   logic                        take;
   logic                        pop;
   logic [PC_W-1:0]             stack_top_entry;
   logic [PC_W-1:0]             pc_q;
   logic [7:0]                  acc_q;
   logic [7:0]                  irqctl_q;
   logic                        ready_q;
   logic                        file_we_q;
   logic [6:0]                  file_addr_q;
   logic [7:0]                  file_data_q;
   logic [1:0]                  cyc_q;
   logic                        irq_set;
   logic                        ctl_write;

   assign kind      = decode(instr_i);
   assign take      = instr_valid_i && ready_q;
   // Pop only once, in the first cycle of a return
   assign pop       = take && is_return(kind);
   assign irq_set   = (state_q == mrx_exec_pkg::MRX_ST_SECOND) && (kind_q == mrx_exec_pkg::MRX_K_IRET);
   assign ctl_write = take && (kind == mrx_exec_pkg::MRX_K_STORE) && (instr_i[6:0] == `MRX_IRQCTL_ADDR);

   // ****************************************************************
   // Hardware stack
   // ****************************************************************
   mrx_stack
   #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH)
   )
   u_stack
   (
      .mclk_i            (mclk_i),
      .rst_i             (rst_i),
      .push_i            (call_push_i),
      .push_data_i       (call_addr_i),
      .pop_i             (pop),
      .stack_top_entry_o (stack_top_entry)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         mrx_exec_pkg::MRX_ST_EXEC:
         begin
            if (pop)
               state_d = mrx_exec_pkg::MRX_ST_SECOND;
         end
         mrx_exec_pkg::MRX_ST_SECOND:
         begin
            if (cyc_q == `MRX_CYC_SHORT)
               state_d = mrx_exec_pkg::MRX_ST_EXEC;
         end
         default:
         begin
            state_d = mrx_exec_pkg::MRX_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         state_q <= mrx_exec_pkg::MRX_ST_EXEC;
      else
         state_q <= state_d;
   end

   // ****************************************************************
   // Cycle count and held kind
   // ****************************************************************
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cyc_q  <= 2'h0;
         kind_q <= mrx_exec_pkg::MRX_K_IDLE;
      end
      else if (take)
      begin
         cyc_q  <= is_return(kind) ? `MRX_CYC_LONG - `MRX_CYC_SHORT : 2'h0;
         kind_q <= kind;
      end
      else if (cyc_q != 2'h0)
         cyc_q <= cyc_q - `MRX_CYC_SHORT;
   end

   // Ready falls for the second cycle of a return
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ready_q <= 1'b0;
      else
         ready_q <= (state_d == mrx_exec_pkg::MRX_ST_EXEC);
   end

   // ****************************************************************
   // Program counter
   // ****************************************************************
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         pc_q <= PC_W'(`MRX_PC_RESET);
      else if (pop)
         pc_q <= stack_top_entry;
      else if (take)
         pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
   end

   // ****************************************************************
   // Accumulator
   // ****************************************************************
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         acc_q <= `MRX_ACC_RESET;
      else if (take && kind == mrx_exec_pkg::MRX_K_LOADLIT)
         acc_q <= instr_i[7:0];
      else if (take && kind == mrx_exec_pkg::MRX_K_RETLIT)
         acc_q <= instr_i[7:0];
   end

   // ****************************************************************
   // File write port
   // ****************************************************************
   // accumulator to file
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         file_we_q   <= 1'b0;
         file_addr_q <= 7'h00;
         file_data_q <= 8'h00;
      end
      else
      begin
         file_we_q <= take && (kind == mrx_exec_pkg::MRX_K_STORE);
         if (take && kind == mrx_exec_pkg::MRX_K_STORE)
         begin
            file_addr_q <= instr_i[6:0];
            file_data_q <= acc_q;
         end
      end
   end

   // ****************************************************************
   // Interrupt control register
   // ****************************************************************
   // A store and an enable change in one cycle cannot both be new:
   // the store is applied first, then the enable bit on top of it
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         irqctl_q <= `MRX_IRQCTL_RESET;
      else
      begin
         if (ctl_write)
            irqctl_q <= acc_q;
         if (irq_set)
            irqctl_q[`MRX_GIE_BIT] <= 1'b1;
         else if (irq_entry_i)
            irqctl_q[`MRX_GIE_BIT] <= 1'b0;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign instr_ready_o           = ready_q;
   assign file_we_o               = file_we_q;
   assign file_addr_o             = file_addr_q;
   assign file_data_o             = file_data_q;
   assign pc_o                    = pc_q;
   assign acc_o                   = acc_q;
   assign interrupt_control_reg_o = irqctl_q;
   assign global_irq_enable_o     = irqctl_q[`MRX_GIE_BIT];

endmodule : mrx_exec

`default_nettype wire

// ### verilog/mrx_stack.sv
`timescale 1ns/1ps
`default_nettype none

module mrx_stack
#(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Stack operations
   input  wire logic             push_i,
   input  wire logic [WIDTH-1:0] push_data_i,
   input  wire logic             pop_i,
   // Top entry
   output logic      [WIDTH-1:0] stack_top_entry_o
);

   localparam int PW = $clog2(DEPTH);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // Circular pointer wraps silently, so depth must be a power of two
   if (DEPTH < 2 || (1 << PW) != DEPTH)
   begin : g_bad_depth
      $error("mrx_stack: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    ptr_q;
   logic [PW-1:0]    ptr_inc;

   assign ptr_inc           = ptr_q + {{(PW-1){1'b0}}, 1'b1};
   assign stack_top_entry_o = mem_q[ptr_q];

   // ****************************************************************
   // Pointer
   // ****************************************************************
   // Overflow overwrites the oldest entry, no error is raised
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ptr_q <= '0;
      else if (push_i && !pop_i)
         ptr_q <= ptr_inc;
      else if (pop_i && !push_i)
         ptr_q <= ptr_q - {{(PW-1){1'b0}}, 1'b1};
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   // Push and pop together replace the top entry
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
         if (rst_i)
            mem_q[i] <= '0;
         else if (push_i && !pop_i && ptr_inc == PW'(i))
            mem_q[i] <= push_data_i;
         else if (push_i && pop_i && ptr_q == PW'(i))
            mem_q[i] <= push_data_i;
      end
   end

endmodule : mrx_stack

`default_nettype wire
